//--- include/csx_params.svh
/*
 holds the offsets, field positions, reset values and timing counts of
 the configuration export block.
 assumes a 12-bit apb byte address and 32-bit data.
*/
`ifndef CSX_PARAMS_SVH
`define CSX_PARAMS_SVH

// ==========================================
// register map
`define CSX_NREG       22
`define CSX_OFF_PRM    12'h004
`define CSX_OFF_BUSN   12'h018
`define CSX_OFF_SEC    12'h01c
`define CSX_OFF_PRBL   12'h024
`define CSX_OFF_PRBH   12'h028
`define CSX_OFF_MSIX   12'h068
`define CSX_OFF_PM     12'h07c
`define CSX_OFF_DEV    12'h088
`define CSX_OFF_LINK   12'h090
`define CSX_OFF_SLOT   12'h098
`define CSX_OFF_ROOT   12'h0a0
`define CSX_OFF_DEV2   12'h0a8
`define CSX_OFF_LINK2  12'h0b0
`define CSX_OFF_IOB    12'h0c0
`define CSX_OFF_IOL    12'h0c4
`define CSX_OFF_NPB    12'h0c8
`define CSX_OFF_NPL    12'h0cc
`define CSX_OFF_PRL    12'h0d0
`define CSX_OFF_MSI    12'h0d4
`define CSX_OFF_BDEV   12'h0d8
`define CSX_OFF_CTRL   12'h0dc
`define CSX_OFF_STAT   12'h0e0

// ==========================================
// fields and reset values
`define CSX_MRRS_HI    14
`define CSX_MRRS_LO    12
`define CSX_MRRS_MAX   3'h5
`define CSX_LBN_BIT    29
`define CSX_CTRL_ROOT  0
`define CSX_CTRL_GEN2  1
`define CSX_CTRL_RUN   2
`define CSX_CTRL_RST   3'h4
`define CSX_LSTS_LO    31
`define CSX_LSTS_HI    46

// ==========================================
// timing
`define CSX_DWELL_CYC  4'h4

`endif

//--- include/csx_pkg.sv
/*
 holds the types of the configuration export block.
 sets its own group codes and takes no constants from the params header.
*/
package csx_pkg;

  // ==========================================
  // group index shown on the shared word
  typedef enum logic [3:0] {
    CSX_G_DEV   = 4'h0, CSX_G_SLOT  = 4'h1, CSX_G_LINK  = 4'h2,
    CSX_G_PRM   = 4'h3, CSX_G_SEC   = 4'h4, CSX_G_IOB   = 4'h5,
    CSX_G_IOL   = 4'h6, CSX_G_NP    = 4'h7, CSX_G_PRBL  = 4'h8,
    CSX_G_PRBH  = 4'h9, CSX_G_PRLL  = 4'ha, CSX_G_PRLH  = 4'hb,
    CSX_G_PM    = 4'hc, CSX_G_MSI   = 4'hd, CSX_G_TC    = 4'he,
    CSX_G_BDEV  = 4'hf
  } csx_group_e;

  typedef logic [31:0] csx_word_t;

endpackage

//--- logic/csx_field.sv
/*
 holds one software-written shadow field.
 assumes the parent decodes the write and supplies the data.
*/
`timescale 1ns/1ns
module csx_field #(
  parameter int         W   = 32,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         we,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ==========================================
  // storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else if (we) begin
      q <= d;
    end
  end

endmodule

//--- logic/csx_export_mux.sv
/*
 holds the configuration export block: apb shadow registers, the round
 robin group walker and the shared word and state bus toward user logic.
 assumes an apb master on pclk and user logic sampling on pclk.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`include "csx_params.svh"
module csx_export_mux (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] shared_config_word,
  output logic      [3:0]  config_group_select,
  output logic      [52:0] config_state_bus
);

  // ==========================================
  // address decode
  localparam logic [11:0] OFFS [`CSX_NREG] = '{
    `CSX_OFF_PRM,  `CSX_OFF_BUSN, `CSX_OFF_SEC,  `CSX_OFF_PRBL,
    `CSX_OFF_PRBH, `CSX_OFF_MSIX, `CSX_OFF_PM,   `CSX_OFF_DEV,
    `CSX_OFF_LINK, `CSX_OFF_SLOT, `CSX_OFF_ROOT, `CSX_OFF_DEV2,
    `CSX_OFF_LINK2, `CSX_OFF_IOB, `CSX_OFF_IOL,  `CSX_OFF_NPB,
    `CSX_OFF_NPL,  `CSX_OFF_PRL,  `CSX_OFF_MSI,  `CSX_OFF_BDEV,
    `CSX_OFF_CTRL, `CSX_OFF_STAT
  };

  logic [`CSX_NREG-1:0] match;
  logic [`CSX_NREG-1:0] we;
  logic                 hit;
  logic                 wr_acc;
  csx_pkg::csx_word_t   rd_vec [`CSX_NREG];
  csx_pkg::csx_word_t   next_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < `CSX_NREG; gi++) begin : g_dec
      assign match[gi] = (paddr == OFFS[gi]);
    end
  endgenerate

  assign hit    = |match;
  assign wr_acc = psel && penable && pwrite;
  // status word is read only, so its write strobe is dropped
  assign we     = wr_acc ? {1'b0, match[`CSX_NREG-2:0]} : '0;

  // ==========================================
  // shadow fields
  logic [15:0] prm_q;
  logic [7:0]  secbus_q;
  logic [7:0]  subbus_q;
  logic [15:0] sec_q;
  logic [31:0] prbl_q;
  logic [11:0] prbh_q;
  logic [15:0] msix_q;
  logic [31:0] pm_q;
  logic [31:0] dev_q;
  logic [31:0] link_q;
  logic [31:0] slot_q;
  logic [7:0]  root_q;
  logic [31:0] dev2_q;
  logic [31:0] link2_q;
  logic [19:0] iob_q;
  logic [19:0] iol_q;
  logic [11:0] npb_q;
  logic [11:0] npl_q;
  logic [11:0] prl_q;
  logic [15:0] msi_q;
  logic [12:0] bdev_q;
  logic [2:0]  ctrl_q;
  logic [31:0] dev_wd;

  // an illegal size code is pinned to the largest legal one
  always_comb begin
    dev_wd = pwdata;
    if (pwdata[`CSX_MRRS_HI:`CSX_MRRS_LO] > `CSX_MRRS_MAX) begin
      dev_wd[`CSX_MRRS_HI:`CSX_MRRS_LO] = `CSX_MRRS_MAX;
    end
  end

  csx_field #(.W(16)) u_prm (
    .pclk (pclk), .presetn (presetn), .we (we[0]),
    .d    (pwdata[15:0]), .q (prm_q)
  );
  csx_field #(.W(8)) u_secbus (
    .pclk (pclk), .presetn (presetn), .we (we[1]),
    .d    (pwdata[15:8]), .q (secbus_q)
  );
  csx_field #(.W(8)) u_subbus (
    .pclk (pclk), .presetn (presetn), .we (we[1]),
    .d    (pwdata[23:16]), .q (subbus_q)
  );
  csx_field #(.W(16)) u_sec (
    .pclk (pclk), .presetn (presetn), .we (we[2]),
    .d    (pwdata[15:0]), .q (sec_q)
  );
  csx_field #(.W(32)) u_prbl (
    .pclk (pclk), .presetn (presetn), .we (we[3]),
    .d    (pwdata), .q (prbl_q)
  );
  csx_field #(.W(12)) u_prbh (
    .pclk (pclk), .presetn (presetn), .we (we[4]),
    .d    (pwdata[11:0]), .q (prbh_q)
  );
  csx_field #(.W(16)) u_msix (
    .pclk (pclk), .presetn (presetn), .we (we[5]),
    .d    (pwdata[15:0]), .q (msix_q)
  );
  csx_field #(.W(32)) u_pm (
    .pclk (pclk), .presetn (presetn), .we (we[6]),
    .d    (pwdata), .q (pm_q)
  );
  csx_field #(.W(32)) u_dev (
    .pclk (pclk), .presetn (presetn), .we (we[7]),
    .d    (dev_wd), .q (dev_q)
  );
  csx_field #(.W(32)) u_link (
    .pclk (pclk), .presetn (presetn), .we (we[8]),
    .d    (pwdata), .q (link_q)
  );
  csx_field #(.W(32)) u_slot (
    .pclk (pclk), .presetn (presetn), .we (we[9]),
    .d    (pwdata), .q (slot_q)
  );
  csx_field #(.W(8)) u_root (
    .pclk (pclk), .presetn (presetn), .we (we[10]),
    .d    (pwdata[7:0]), .q (root_q)
  );
  csx_field #(.W(32)) u_dev2 (
    .pclk (pclk), .presetn (presetn), .we (we[11]),
    .d    (pwdata), .q (dev2_q)
  );
  csx_field #(.W(32)) u_link2 (
    .pclk (pclk), .presetn (presetn), .we (we[12]),
    .d    (pwdata), .q (link2_q)
  );
  csx_field #(.W(20)) u_iob (
    .pclk (pclk), .presetn (presetn), .we (we[13]),
    .d    (pwdata[19:0]), .q (iob_q)
  );
  csx_field #(.W(20)) u_iol (
    .pclk (pclk), .presetn (presetn), .we (we[14]),
    .d    (pwdata[19:0]), .q (iol_q)
  );
  csx_field #(.W(12)) u_npb (
    .pclk (pclk), .presetn (presetn), .we (we[15]),
    .d    (pwdata[11:0]), .q (npb_q)
  );
  csx_field #(.W(12)) u_npl (
    .pclk (pclk), .presetn (presetn), .we (we[16]),
    .d    (pwdata[11:0]), .q (npl_q)
  );
  csx_field #(.W(12)) u_prl (
    .pclk (pclk), .presetn (presetn), .we (we[17]),
    .d    (pwdata[11:0]), .q (prl_q)
  );
  csx_field #(.W(16)) u_msi (
    .pclk (pclk), .presetn (presetn), .we (we[18]),
    .d    (pwdata[15:0]), .q (msi_q)
  );
  csx_field #(.W(13)) u_bdev (
    .pclk (pclk), .presetn (presetn), .we (we[19]),
    .d    (pwdata[12:0]), .q (bdev_q)
  );
  csx_field #(.W(3), .RST(`CSX_CTRL_RST)) u_ctrl (
    .pclk (pclk), .presetn (presetn), .we (we[20]),
    .d    (pwdata[2:0]), .q (ctrl_q)
  );

  // ==========================================
  // derived values
  logic        rp;
  logic [31:0] link_x;

  assign rp = ctrl_q[`CSX_CTRL_ROOT];

  // notification bit is fixed by generation, never by software
  always_comb begin
    link_x                = link_q;
    link_x[`CSX_LBN_BIT]  = ctrl_q[`CSX_CTRL_GEN2];
  end

  // ==========================================
  // group walker
  csx_pkg::csx_group_e grp;
  logic [3:0]          dwell;
  logic                tick;

  assign tick = ctrl_q[`CSX_CTRL_RUN] && (dwell == `CSX_DWELL_CYC - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell <= 4'h0;
    end else if (!ctrl_q[`CSX_CTRL_RUN] || tick) begin
      dwell <= 4'h0;
    end else begin
      dwell <= dwell + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp <= csx_pkg::CSX_G_DEV;
    end else if (tick) begin
      grp <= csx_pkg::csx_group_e'(grp + 4'h1);
    end
  end

  // ==========================================
  // export multiplexer
  csx_pkg::csx_word_t next_word;
  logic [52:0]        next_sts;

  always_comb begin
    case (grp)
      csx_pkg::CSX_G_DEV: begin
        next_word = {dev_q[15:0], dev2_q[15:0]};
      end
      csx_pkg::CSX_G_SLOT: begin
        next_word = rp ? slot_q : 32'h0000_0000;
      end
      csx_pkg::CSX_G_LINK: begin
        next_word = {link_x[15:0], link2_q[15:0]};
      end
      csx_pkg::CSX_G_PRM: begin
        next_word = {8'h00, prm_q, rp ? root_q : 8'h00};
      end
      csx_pkg::CSX_G_SEC: begin
        next_word = rp ? {sec_q, secbus_q, subbus_q} : 32'h0000_0000;
      end
      csx_pkg::CSX_G_IOB: begin
        next_word = rp ? {12'h000, iob_q} : 32'h0000_0000;
      end
      csx_pkg::CSX_G_IOL: begin
        next_word = rp ? {12'h000, iol_q} : 32'h0000_0000;
      end
      csx_pkg::CSX_G_NP: begin
        next_word = rp ? {8'h00, npb_q, npl_q} : 32'h0000_0000;
      end
      csx_pkg::CSX_G_PRBL: begin
        next_word = rp ? prbl_q : 32'h0000_0000;
      end
      csx_pkg::CSX_G_PRBH: begin
        next_word = rp ? {20'h00000, prbh_q} : 32'h0000_0000;
      end
      csx_pkg::CSX_G_PRLL: begin
        next_word = rp ? {20'h00000, prl_q} : 32'h0000_0000;
      end
      csx_pkg::CSX_G_PM: begin
        next_word = rp ? pm_q : 32'h0000_0000;
      end
      csx_pkg::CSX_G_MSI: begin
        next_word = {msix_q, msi_q};
      end
      csx_pkg::CSX_G_BDEV: begin
        next_word = {16'h0000, 3'h0, bdev_q};
      end
      default: begin
        // upper prefetch limit and traffic class groups carry nothing
        next_word = 32'h0000_0000;
      end
    endcase
  end

  // link status rides the state bus so index 2 loses only link2_q[31:16]
  always_comb begin
    next_sts                           = '0;
    next_sts[`CSX_LSTS_HI:`CSX_LSTS_LO] = link_x[31:16];
  end

  // word and index leave on the same edge so they always pair up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_config_word  <= 32'h0000_0000;
      config_group_select <= 4'h0;
    end else begin
      shared_config_word  <= next_word;
      config_group_select <= grp;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_state_bus <= '0;
    end else begin
      config_state_bus <= next_sts;
    end
  end

  // ==========================================
  // register read back
  always_comb begin
    rd_vec[0]  = {16'h0000, prm_q};
    rd_vec[1]  = {8'h00, subbus_q, secbus_q, 8'h00};
    rd_vec[2]  = {16'h0000, sec_q};
    rd_vec[3]  = prbl_q;
    rd_vec[4]  = {20'h00000, prbh_q};
    rd_vec[5]  = {16'h0000, msix_q};
    rd_vec[6]  = pm_q;
    rd_vec[7]  = dev_q;
    rd_vec[8]  = link_x;
    rd_vec[9]  = slot_q;
    rd_vec[10] = {24'h000000, root_q};
    rd_vec[11] = dev2_q;
    rd_vec[12] = link2_q;
    rd_vec[13] = {12'h000, iob_q};
    rd_vec[14] = {12'h000, iol_q};
    rd_vec[15] = {20'h00000, npb_q};
    rd_vec[16] = {20'h00000, npl_q};
    rd_vec[17] = {20'h00000, prl_q};
    rd_vec[18] = {16'h0000, msi_q};
    rd_vec[19] = {19'h00000, bdev_q};
    rd_vec[20] = {29'h00000000, ctrl_q};
    rd_vec[21] = {28'h0000000, grp};
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < `CSX_NREG; i++) begin
      if (match[i]) begin
        next_rdata = next_rdata | rd_vec[i];
      end
    end
  end

  // ==========================================
  // apb answer
  // read data is caught in the setup cycle, so access needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  assign pready  = psel && penable;
  assign pslverr = psel && penable && !hit;

endmodule

//--- verif/csx_export_mux_assertions.sv
/*
 port checker for the config export block.
 assumes it is bound to csx_export_mux, one pclk domain.
*/
`timescale 1ns/1ns
module csx_export_mux_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] shared_config_word,
  input wire logic [3:0]  config_group_select,
  input wire logic [52:0] config_state_bus
);
  // ==========================================
  // group walk
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_step;
    $changed(config_group_select);
  endsequence
  sequence s_hold;
    $stable(config_group_select) [*3];
  endsequence
  a_walk_step: assert property (
    s_step |-> config_group_select == $past(config_group_select) + 4'h1) else $error("select skipped a group");
  a_dwell_hold: assert property (
    s_step |=> s_hold) else $error("group shown under four cycles");
  // ==========================================
  // word layout
  a_mrrs_code: assert property (
    config_group_select == 4'h0 |-> shared_config_word[30:28] <= 3'h5) else $error("read size code above 101");
  a_state_pad: assert property (
    config_state_bus[30:0] == '0 && config_state_bus[52:47] == '0) else $error("state bus spare bits set");
  a_prm_pad: assert property (
    config_group_select == 4'h3 |-> shared_config_word[31:24] == 8'h0) else $error("group 3 pad set");
  a_io_pad: assert property (
    config_group_select inside {4'h5, 4'h6} |-> shared_config_word[31:20] == 12'h0) else $error("io pad set");
  a_np_pad: assert property (
    config_group_select == 4'h7 |-> shared_config_word[31:24] == 8'h0) else $error("group 7 pad set");
  a_prb_pad: assert property (
    config_group_select == 4'h9 |-> shared_config_word[31:12] == 20'h0) else $error("group 9 pad set");
  a_empty_groups: assert property (
    config_group_select inside {4'hb, 4'he} |-> shared_config_word == '0) else $error("empty group nonzero");
  // ==========================================
  // apb answer
  a_ready_access: assert property (
    psel && penable |-> pready) else $error("access without ready");
  a_err_access: assert property (
    pslverr |-> psel && penable) else $error("error outside access");
endmodule

bind csx_export_mux csx_export_mux_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .shared_config_word(shared_config_word), .config_group_select(config_group_select),
  .config_state_bus(config_state_bus));

//--- verif/csx_user_model.sv
/*
 user logic model that files each exported word under its index.
 assumes word and select are registered on pclk.
*/
`timescale 1ns/1ns
module csx_user_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] shared_config_word,
  input  wire logic [3:0]  config_group_select,
  output logic      [31:0] cap_word [16]
);
  // ==========================================
  // capture
  // word and index taken in one cycle, never mixed across groups
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++)
        cap_word[i] <= '0;
    end else begin
      cap_word[config_group_select] <= shared_config_word;
    end
  end
endmodule

//--- verif/config_space_export_mux_tb.sv
/*
 self-checking bench for the config export block.
 assumes apb with zero wait states and a 4 cycle dwell.
*/
`timescale 1ns/1ns
`include "csx_params.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("Error %0t: %h vs %h", $time, (a), (b)); end end
module config_space_export_mux_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, shared_config_word, rd;
  logic [3:0]  config_group_select, s;
  logic [52:0] config_state_bus;
  logic [31:0] cap_word [16];
  logic [31:0] v [20];
  int          mismatches, checks_done, cyc;
  localparam logic [11:0] ADR [20] = '{`CSX_OFF_PRM, `CSX_OFF_BUSN, `CSX_OFF_SEC, `CSX_OFF_PRBL,
    `CSX_OFF_PRBH, `CSX_OFF_MSIX, `CSX_OFF_PM, `CSX_OFF_DEV, `CSX_OFF_LINK, `CSX_OFF_SLOT, `CSX_OFF_ROOT,
    `CSX_OFF_DEV2, `CSX_OFF_LINK2, `CSX_OFF_IOB, `CSX_OFF_IOL, `CSX_OFF_NPB, `CSX_OFF_NPL, `CSX_OFF_PRL,
    `CSX_OFF_MSI, `CSX_OFF_BDEV};

  csx_export_mux uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shared_config_word(shared_config_word), .config_group_select(config_group_select),
    .config_state_bus(config_state_bus));
  csx_user_model u_user (.pclk(pclk), .presetn(presetn), .shared_config_word(shared_config_word),
    .config_group_select(config_group_select), .cap_word(cap_word));

  // ==========================================
  // expectations
  function automatic logic [31:0] exp_word(input logic [3:0] g, input logic rp);
    logic [2:0]  m;
    logic [31:0] w;
    m = (v[7][14:12] > 3'h5) ? 3'h5 : v[7][14:12];
    case (g)
      4'h0: w = {v[7][15], m, v[7][11:0], v[11][15:0]};
      4'h1: w = v[9];
      4'h2: w = {v[8][15:0], v[12][15:0]};
      4'h3: w = {8'h0, v[0][15:0], rp ? v[10][7:0] : 8'h0};
      4'h4: w = {v[2][15:0], v[1][15:8], v[1][23:16]};
      4'h5: w = {12'h0, v[13][19:0]};
      4'h6: w = {12'h0, v[14][19:0]};
      4'h7: w = {8'h0, v[15][11:0], v[16][11:0]};
      4'h8: w = v[3];
      4'h9: w = {20'h0, v[4][11:0]};
      4'ha: w = {20'h0, v[17][11:0]};
      4'hc: w = v[6];
      4'hd: w = {v[5][15:0], v[18][15:0]};
      4'hf: w = {19'h0, v[19][12:0]};
      default: w = '0;
    endcase
    exp_word = (!rp && (g inside {4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc})) ? '0 : w;
  endfunction

  // ==========================================
  // apb master, holds the request until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50)
      mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================
  // clock, timeout, sequence
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      tally_and_finish;
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'h5ea3));
    repeat (16) @(posedge pclk);
    `CHK(shared_config_word, 32'h0)
    presetn <= 1'b1;
    apb(1'b0, `CSX_OFF_CTRL, '0);
    `CHK(rd, 32'h4)
    // root port gen2 first, then endpoint gen1; size code at 111 then 101
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `CSX_OFF_CTRL, p ? 32'h4 : 32'h7);
      for (int i = 0; i < 20; i++) begin
        v[i] = $urandom;
        if (i == 7)
          v[i][14:12] = p ? 3'h5 : 3'h7;
        apb(1'b1, ADR[i], v[i]);
      end
      repeat (70) @(posedge pclk);
      for (int g = 0; g < 16; g++)
        `CHK(cap_word[g], exp_word(g[3:0], !p[0]))
      `CHK(config_state_bus[46:31], {v[8][31:30], !p[0], v[8][28:16]})
    end
    apb(1'b0, 12'hff0, '0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    // run cleared: walk must stop where it is
    apb(1'b1, `CSX_OFF_CTRL, '0);
    // a tick on the write edge still lands, so settle two edges first
    repeat (2) @(posedge pclk);
    s = config_group_select;
    repeat (12) @(posedge pclk);
    `CHK(config_group_select, s)
    // status word is read only: a write is ignored without error
    apb(1'b1, `CSX_OFF_STAT, $urandom);
    `CHK(er, 1'b0)
    apb(1'b0, `CSX_OFF_STAT, '0);
    `CHK(rd, {28'h0, s})
    // reset with the walk stopped: outputs clear at once, control back to run
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(shared_config_word, 32'h0)
    `CHK(config_group_select, 4'h0)
    `CHK(config_state_bus, 53'h0)
    presetn <= 1'b1;
    apb(1'b0, `CSX_OFF_CTRL, '0);
    `CHK(rd, 32'h4)
    tally_and_finish;
  end
endmodule
